// File: design/amp_regs_pkg.sv
package amp_regs_pkg;

  localparam logic [7:0]  OFF_ID      = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h01;
  localparam logic [7:0]  OFF_EVENT   = 8'h02;
  localparam logic [7:0]  OFF_MASK    = 8'h03;
  localparam logic [7:0]  OFF_CTRL    = 8'h04;
  localparam logic [7:0]  OFF_BATT    = 8'h6D;
  localparam logic [7:0]  OFF_HEAT    = 8'h6E;
  localparam int          NUM_CFG     = 15;
  localparam logic [7:0]  CFG_OFF [NUM_CFG] = '{
    8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
    8'h0F, 8'h10, 8'h11, 8'h21, 8'h60, 8'h61, 8'h62};

  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [15:0] MASK_RESET  = 16'hFFFF;
  localparam logic [15:0] CTRL_RESET  = 16'h6007;
  localparam logic [15:0] RESET_KEY   = 16'h55AA;
  localparam logic [15:0] EVENT_BITS  = 16'h7FFF;
  localparam logic [4:0]  DEV_BASE    = 5'h0D;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;

  // positions inside the synchronised input vector
  localparam int SY_SCL     = 19;
  localparam int SY_SDA     = 18;
  localparam int SY_AD2     = 17;
  localparam int SY_AD1     = 16;
  localparam int SY_VDD_HI  = 15;
  localparam int SY_VDD_LO  = 14;
  localparam int SY_WIDTH   = 20;
  // bus lines idle high, so the synchronisers leave reset at that level
  localparam logic [SY_WIDTH-1:0] SY_IDLE = 20'hC0000;

  localparam int BIT_UV     = 14;
  localparam int BIT_WDOG   = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_PTR  = 3'b011,
    ST_WR   = 3'b010,
    ST_RD   = 3'b110,
    ST_SKIP = 3'b111
  } bus_state_t;

endpackage

// File: design/amp_status_id_regs.sv
`timescale 1ns/100ps
module amp_status_id_regs
  import amp_regs_pkg::*;
#(
  // arbitrary neutral identity value
  parameter logic [15:0] CHIP_ID = 16'h0A5C
)(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output wire logic        sdaOut,
  output wire logic        sdaOe,
  input  wire logic        addrSel1,
  input  wire logic        addrSel2,
  input  wire logic        vddBelowLow,
  input  wire logic        vddAboveHigh,
  input  wire logic        boostActive,
  input  wire logic        procAckReq,
  input  wire logic        boostOverCur,
  input  wire logic        boostOverVolt,
  input  wire logic        boostStarted,
  input  wire logic        ampSwitching,
  input  wire logic        ampClipping,
  input  wire logic        earlyClip,
  input  wire logic        watchdogFire,
  input  wire logic        refClockMissing,
  input  wire logic        clocksStable,
  input  wire logic        ampOverCur,
  input  wire logic        overheat,
  input  wire logic        pllLocked,
  input  wire logic [15:0] batteryLevel,
  input  wire logic [15:0] dieHeat,
  output logic      [15:0] sysControl,
  output logic             configDefaults,
  output logic             deviceRestart,
  output logic             eventIrq
);

  initial begin
    if (CHIP_ID == RESET_KEY)
      $error("identity value must differ from the reset key");
  end

  ////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers

  logic [1:0]          rstPipe;
  logic                rstN;
  logic [SY_WIDTH-1:0] rawIn;
  logic [SY_WIDTH-1:0] syncA;
  logic [SY_WIDTH-1:0] syncB;
  logic                sclD;
  logic                sdaD;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  assign rawIn = {sclIn, sdaIn, addrSel2, addrSel1, vddAboveHigh,
                  vddBelowLow, boostActive, procAckReq, boostOverCur,
                  boostOverVolt, boostStarted, ampSwitching, ampClipping,
                  watchdogFire, refClockMissing, clocksStable, ampOverCur,
                  earlyClip, overheat, pllLocked};

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      syncA <= SY_IDLE;
      syncB <= SY_IDLE;
      sclD  <= 1'b1;
      sdaD  <= 1'b1;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
      sclD  <= syncB[SY_SCL];
      sdaD  <= syncB[SY_SDA];
    end
  end

  logic sclNow;
  logic sdaNow;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  assign sclNow   = syncB[SY_SCL];
  assign sdaNow   = syncB[SY_SDA];
  assign sclRise  = sclNow & ~sclD;
  assign sclFall  = ~sclNow & sclD;
  assign startDet = sclNow & sclD & sdaD & ~sdaNow;
  assign stopDet  = sclNow & sclD & ~sdaD & sdaNow;

  ////////////////////////////////////////////////////////////////////
  // live status word

  logic        uvReg;
  logic [15:0] statusWord;
  logic [15:0] statusPrev;
  logic [15:0] setBits;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      uvReg <= 1'b0;
    end else if (syncB[SY_VDD_LO]) begin
      uvReg <= 1'b1;
    end else if (syncB[SY_VDD_HI]) begin
      uvReg <= 1'b0;
    end
  end

  assign statusWord[15]    = 1'b0;
  assign statusWord[14]    = uvReg;
  assign statusWord[13]    = syncB[13];
  assign statusWord[12]    = syncB[12];
  assign statusWord[11:10] = syncB[11:10];
  assign statusWord[9]     = syncB[9];
  assign statusWord[8]     = syncB[8];
  assign statusWord[7]     = syncB[7];
  assign statusWord[6]     = syncB[6];
  assign statusWord[5]     = syncB[5];
  assign statusWord[4]     = syncB[4];
  assign statusWord[3]     = syncB[3];
  assign statusWord[2]     = syncB[2];
  assign statusWord[1]     = syncB[1];
  assign statusWord[0]     = syncB[0];

  assign setBits = (statusWord ^ statusPrev) & EVENT_BITS;

  ////////////////////////////////////////////////////////////////////
  // serial register port

  bus_state_t  state;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftReg;
  logic        inAck;
  logic        hiByte;
  logic        mAck;
  logic [7:0]  regPtr;
  logic [7:0]  wrHi;
  logic [15:0] txWord;
  logic        sdaOeReg;
  logic        wrStrobe;
  logic [15:0] wrData;
  logic [7:0]  wrAddr;
  logic        evClear;
  logic [7:0]  lookPtr;
  logic [15:0] rdData;
  logic        devMatch;
  logic [7:0]  curByte;
  logic        loadNow;

  assign devMatch = shiftReg[7:1] ==
                    {DEV_BASE, syncB[SY_AD2], syncB[SY_AD1]};
  // during a read the next word is fetched ahead of the increment
  assign lookPtr  = (state == ST_RD) ? regPtr + 8'h01 : regPtr;
  assign curByte  = hiByte ? txWord[15:8] : txWord[7:0];
  assign loadNow  = sclFall && ((state == ST_DEV && !inAck &&
                    bitCnt == BYTE_BITS && devMatch && shiftReg[0]) ||
                    (state == ST_RD && inAck && mAck && !hiByte));
  assign sdaOut   = 1'b0;
  assign sdaOe    = sdaOeReg;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state    <= ST_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      inAck    <= 1'b0;
      hiByte   <= 1'b1;
      mAck     <= 1'b0;
      regPtr   <= 8'h00;
      wrHi     <= 8'h00;
      txWord   <= 16'h0000;
      sdaOeReg <= 1'b0;
      wrStrobe <= 1'b0;
      wrData   <= 16'h0000;
      wrAddr   <= 8'h00;
      evClear  <= 1'b0;
    end else begin
      wrStrobe <= 1'b0;
      evClear  <= 1'b0;
      if (startDet) begin
        state    <= ST_DEV;
        bitCnt   <= 4'h0;
        inAck    <= 1'b0;
        sdaOeReg <= 1'b0;
      end else if (stopDet) begin
        state    <= ST_IDLE;
        inAck    <= 1'b0;
        sdaOeReg <= 1'b0;
      end else if (sclRise) begin
        if (state == ST_RD) begin
          if (inAck) begin
            mAck <= ~sdaNow;
          end else begin
            bitCnt <= bitCnt + 4'h1;
          end
        end else if (!inAck && state != ST_IDLE && state != ST_SKIP) begin
          shiftReg <= {shiftReg[6:0], sdaNow};
          bitCnt   <= bitCnt + 4'h1;
        end
      end else if (sclFall) begin
        case (state)
          ST_DEV, ST_PTR, ST_WR: begin
            if (inAck) begin
              inAck    <= 1'b0;
              bitCnt   <= 4'h0;
              sdaOeReg <= 1'b0;
              if (state == ST_DEV && shiftReg[0]) begin
                state    <= ST_RD;
                hiByte   <= 1'b1;
                sdaOeReg <= ~txWord[15];
              end else if (state == ST_DEV) begin
                state <= ST_PTR;
              end else if (state == ST_PTR) begin
                state  <= ST_WR;
                hiByte <= 1'b1;
              end
            end else if (bitCnt == BYTE_BITS) begin
              inAck    <= 1'b1;
              sdaOeReg <= 1'b1;
              if (state == ST_DEV) begin
                if (!devMatch) begin
                  state    <= ST_SKIP;
                  inAck    <= 1'b0;
                  sdaOeReg <= 1'b0;
                end else if (shiftReg[0]) begin
                  txWord  <= rdData;
                  evClear <= lookPtr == OFF_EVENT;
                end
              end else if (state == ST_PTR) begin
                regPtr <= shiftReg;
              end else if (hiByte) begin
                wrHi   <= shiftReg;
                hiByte <= 1'b0;
              end else begin
                wrStrobe <= 1'b1;
                wrData   <= {wrHi, shiftReg};
                wrAddr   <= regPtr;
                regPtr   <= regPtr + 8'h01;
                hiByte   <= 1'b1;
              end
            end
          end
          ST_RD: begin
            if (inAck) begin
              inAck  <= 1'b0;
              bitCnt <= 4'h0;
              if (!mAck) begin
                state    <= ST_SKIP;
                sdaOeReg <= 1'b0;
              end else if (hiByte) begin
                hiByte   <= 1'b0;
                sdaOeReg <= ~txWord[7];
              end else begin
                hiByte   <= 1'b1;
                regPtr   <= lookPtr;
                txWord   <= rdData;
                evClear  <= lookPtr == OFF_EVENT;
                sdaOeReg <= ~rdData[15];
              end
            end else if (bitCnt == BYTE_BITS) begin
              inAck    <= 1'b1;
              sdaOeReg <= 1'b0;
            end else begin
              sdaOeReg <= ~curByte[3'd7 - bitCnt[2:0]];
            end
          end
          default: begin
            sdaOeReg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register bank

  logic [15:0] maskReg;
  logic [15:0] ctrlReg;
  logic [15:0] latch;
  logic [15:0] cfgReg [NUM_CFG];
  logic        keyHit;

  assign keyHit = wrStrobe && wrAddr == OFF_ID && wrData == RESET_KEY;
  assign sysControl = ctrlReg;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      maskReg        <= MASK_RESET;
      ctrlReg        <= CTRL_RESET;
      configDefaults <= 1'b0;
    end else begin
      configDefaults <= keyHit;
      if (keyHit) begin
        maskReg <= MASK_RESET;
        ctrlReg <= CTRL_RESET;
      end else if (wrStrobe && wrAddr == OFF_MASK) begin
        maskReg <= wrData;
      end else if (wrStrobe && wrAddr == OFF_CTRL) begin
        ctrlReg <= wrData;
      end
    end
  end

  for (genvar g = 0; g < NUM_CFG; g++) begin : gCfg
    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        cfgReg[g] <= CFG_RESET;
      end else if (keyHit) begin
        cfgReg[g] <= CFG_RESET;
      end else if (wrStrobe && wrAddr == CFG_OFF[g]) begin
        cfgReg[g] <= wrData;
      end
    end
  end

  always_comb begin
    rdData = 16'h0000;
    case (lookPtr)
      OFF_ID:     rdData = CHIP_ID;
      OFF_STATUS: rdData = statusWord;
      OFF_EVENT:  rdData = latch;
      OFF_MASK:   rdData = maskReg;
      OFF_CTRL:   rdData = ctrlReg;
      OFF_BATT:   rdData = batteryLevel;
      OFF_HEAT:   rdData = dieHeat;
      default: begin
        for (int i = 0; i < NUM_CFG; i++) begin
          if (lookPtr == CFG_OFF[i])
            rdData = cfgReg[i];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // events, interrupt and watchdog restart

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      statusPrev <= 16'h0000;
      latch      <= 16'h0000;
    end else begin
      statusPrev <= statusWord;
      // only the bits handed out are cleared; new changes win
      latch <= (latch & ~(evClear ? txWord : 16'h0000)) | setBits;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      eventIrq      <= 1'b0;
      deviceRestart <= 1'b0;
    end else begin
      eventIrq      <= |(latch[14:0] & ~maskReg[14:0]);
      deviceRestart <= statusWord[BIT_WDOG] & ~statusPrev[BIT_WDOG];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstN);

  sequence s_key_write;
    wrStrobe && wrAddr == OFF_ID && wrData == RESET_KEY;
  endsequence
  sequence s_event_load;
    loadNow && lookPtr == OFF_EVENT;
  endsequence

  property p_id_read;
    (loadNow && lookPtr == OFF_ID) |=> txWord == CHIP_ID;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity read returned wrong value");

  property p_key_restore;
    s_key_write |=> configDefaults && maskReg == MASK_RESET
                    && ctrlReg == CTRL_RESET ##1 !configDefaults;
  endproperty
  a_key_restore: assert property (p_key_restore)
    else $error("reset key did not restore defaults");

  property p_uv_hyst;
    (syncB[SY_VDD_HI] && !syncB[SY_VDD_LO]) |=> !statusWord[BIT_UV];
  endproperty
  a_uv_hyst: assert property (p_uv_hyst)
    else $error("undervoltage flag not cleared above high level");

  property p_status_read;
    (loadNow && lookPtr == OFF_STATUS) |=>
      txWord == $past(statusWord) && !txWord[15];
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not match live conditions");

  property p_restart;
    $rose(syncB[BIT_WDOG]) |=> deviceRestart ##1 !deviceRestart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("watchdog did not pulse restart");

  property p_event_clear;
    s_event_load |=> evClear
      ##1 (latch & $past(txWord)) == ($past(setBits) & $past(txWord));
  endproperty
  a_event_clear: assert property (p_event_clear)
    else $error("event latch not cleared by read");

  property p_event_set;
    setBits[0] |=> latch[0];
  endproperty
  a_event_set: assert property (p_event_set)
    else $error("event lost against clear");

  property p_irq_mask;
    (maskReg[14:0] == 15'h7FFF) |=> !eventIrq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("masked event raised interrupt");

  property p_addr_inc;
    (state == ST_RD && sclFall && inAck && mAck && !hiByte)
      |=> regPtr == $past(regPtr) + 8'h01 && hiByte;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("read address did not advance");

  property p_id_ignore;
    (wrStrobe && wrAddr == OFF_ID && wrData != RESET_KEY)
      |=> !configDefaults && $stable(maskReg) && $stable(ctrlReg);
  endproperty
  a_id_ignore: assert property (p_id_ignore)
    else $error("plain identity write had an effect");

endmodule

// File: test/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model #(
  parameter int HALF = 6
)(
  input  wire logic       clock,
  input  wire logic       sdaLine,
  input  wire logic [6:0] devAddr,
  output logic            sclLine,
  output logic            sdaLow
);
  initial begin
    sclLine = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // data moves only while the clock line is low
  task automatic xfer(input logic b, output logic r);
    sdaLow = !b;
    tick(HALF);
    sclLine = 1'b1;
    tick(HALF);
    r = sdaLine;
    sclLine = 1'b0;
    tick(2);
  endtask
  // also serves as repeated start with the clock low
  task automatic start();
    sdaLow = 1'b0;
    tick(HALF);
    sclLine = 1'b1;
    tick(HALF);
    sdaLow = 1'b1;
    tick(HALF);
    sclLine = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    tick(HALF);
    sclLine = 1'b1;
    tick(HALF);
    sdaLow = 1'b0;
    tick(HALF);
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = !r;
  endtask
  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(!ackIt, r);
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [15:0] d,
                          output logic [3:0] k);
    start();
    sendByte({devAddr, 1'b0}, k[3]);
    sendByte(a, k[2]);
    sendByte(d[15:8], k[1]);
    sendByte(d[7:0], k[0]);
    stop();
  endtask
  // words arrive high byte first; the last low byte is refused
  task automatic regRead(input logic [7:0] a, input int n,
                         output logic [31:0] q, output logic [2:0] k);
    logic [7:0] hi;
    logic [7:0] lo;
    start();
    sendByte({devAddr, 1'b0}, k[2]);
    sendByte(a, k[1]);
    start();
    sendByte({devAddr, 1'b1}, k[0]);
    for (int j = 0; j < n; j++) begin
      recvByte(1'b1, hi);
      recvByte(j < n - 1, lo);
      q = {q[15:0], hi, lo};
    end
    stop();
  endtask
endmodule

// File: test/amp_status_id_regs_tb_top.sv
`timescale 1ns/100ps
module amp_status_id_regs_tb_top;
  import amp_regs_pkg::*;
  // arbitrary identity value
  localparam logic [15:0] TEST_ID = 16'h3C96;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        addrSel1;
  logic        addrSel2;
  logic        vBelow;
  logic        vAbove;
  logic [15:0] flags;
  logic [15:0] batt;
  logic [15:0] sysControl;
  wire logic   sclLine;
  wire logic   sdaLow;
  wire logic   sdaOe;
  wire logic   configDefaults;
  wire logic   deviceRestart;
  wire logic   eventIrq;
  wire logic   sdaLine = !(sdaLow || sdaOe);
  logic [1:0]  uvIn [3] = '{2'b10, 2'b00, 2'b01};
  logic        uvExp [3] = '{1'b1, 1'b1, 1'b0};
  int          miscompares = 0;
  int          n_compared = 0;
  int          defaultsSeen = 0;
  int          restartSeen = 0;

  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (configDefaults === 1'b1) defaultsSeen++;
    if (deviceRestart === 1'b1) restartSeen++;
  end

  amp_status_id_regs #(.CHIP_ID(TEST_ID)) amp_status_id_regs_i (
    .clock(clock), .resetn(resetn), .sclIn(sclLine), .sdaIn(sdaLine),
    .sdaOut(), .sdaOe(sdaOe), .addrSel1(addrSel1), .addrSel2(addrSel2),
    .vddBelowLow(vBelow), .vddAboveHigh(vAbove),
    .boostActive(flags[13]), .procAckReq(flags[12]),
    .boostOverCur(flags[11]), .boostOverVolt(flags[10]),
    .boostStarted(flags[9]), .ampSwitching(flags[8]),
    .ampClipping(flags[7]), .watchdogFire(flags[6]),
    .refClockMissing(flags[5]), .clocksStable(flags[4]),
    .ampOverCur(flags[3]), .earlyClip(flags[2]), .overheat(flags[1]),
    .pllLocked(flags[0]), .batteryLevel(batt), .dieHeat(~batt),
    .sysControl(sysControl), .configDefaults(configDefaults),
    .deviceRestart(deviceRestart), .eventIrq(eventIrq));

  i2c_master_model i2c_master_model_i (
    .clock(clock), .sdaLine(sdaLine),
    .devAddr({DEV_BASE, addrSel2, addrSel1}),
    .sclLine(sclLine), .sdaLow(sdaLow));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] expStat(input logic uv);
    return {1'b0, uv, flags[13:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [3:0] k;
    i2c_master_model_i.regWrite(a, d, k);
    check("write acks", {12'h000, k}, 16'h000F);
  endtask
  task automatic rd(input logic [7:0] a, input int n,
                    output logic [31:0] q);
    logic [2:0] k;
    i2c_master_model_i.regRead(a, n, q, k);
    check("read acks", {13'h0000, k}, 16'h0007);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    miscompares++;
    wrap_up();
  end
  initial begin
    logic [31:0] q;
    logic [15:0] d;
    int          idx;
    void'($urandom(32'hD315C283));
    {addrSel2, addrSel1} = 2'($urandom);
    vBelow = 1'b0;
    vAbove = 1'b1;
    flags = 16'h0000;
    batt = 16'h0000;
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    rd(OFF_MASK, 1, q);
    check("mask reset", q[15:0], MASK_RESET);
    rd(8'h07, 1, q);
    check("unmapped read", q[15:0], 16'h0000);
    rd(OFF_ID, 2, q);
    check("identity", q[31:16], TEST_ID);
    check("next word", q[15:0], expStat(1'b0));
    // random conditions, config data and refused status writes
    for (int i = 0; i < 4; i++) begin
      flags = 16'($urandom) & 16'h3FBF;
      vBelow = 1'($urandom);
      vAbove = !vBelow;
      batt = 16'($urandom);
      idx = $urandom_range(NUM_CFG - 1);
      d = 16'($urandom);
      wr(CFG_OFF[idx], d);
      wr(OFF_STATUS, ~d);
      rd(CFG_OFF[idx], 1, q);
      check("config", q[15:0], d);
      rd(OFF_STATUS, 1, q);
      check("status", q[15:0] & 16'hFF00, expStat(vBelow) & 16'hFF00);
      check("status", q[15:0] & 16'hFF, expStat(vBelow) & 16'hFF);
      rd(OFF_BATT, 1, q);
      check("battery", q[15:0], batt);
    end
    for (int i = 0; i < 3; i++) begin
      {vBelow, vAbove} = uvIn[i];
      rd(OFF_STATUS, 1, q);
      check("undervoltage", {15'h0000, q[14]}, {15'h0000, uvExp[i]});
    end
    idx = restartSeen;
    flags[6] = 1'b1;
    rd(OFF_STATUS, 1, q);
    check("watchdog status", q[15:0], expStat(1'b0));
    check("restarts", 16'(restartSeen - idx), 16'h0001);
    flags[6] = 1'b0;
    rd(OFF_EVENT, 1, q);
    rd(OFF_EVENT, 1, q);
    check("events after read", q[15:0], 16'h0000);
    wr(OFF_MASK, 16'hFFFE);
    flags[0] = !flags[0];
    rd(OFF_MASK, 1, q);
    check("mask", q[15:0], 16'hFFFE);
    check("irq unmasked", {15'h0000, eventIrq}, 16'h0001);
    rd(OFF_EVENT, 1, q);
    check("event bit", q[15:0], 16'h0001);
    check("irq after read", {15'h0000, eventIrq}, 16'h0000);
    flags[1] = !flags[1];
    rd(OFF_MASK, 1, q);
    check("irq masked", {15'h0000, eventIrq}, 16'h0000);
    // identity writes: plain value refused, key restores defaults
    wr(CFG_OFF[0], 16'hA5A5);
    wr(OFF_CTRL, 16'h1235);
    wr(OFF_ID, 16'hAA55);
    rd(OFF_ID, 1, q);
    check("identity kept", q[15:0], TEST_ID);
    check("control kept", sysControl, 16'h1235);
    idx = defaultsSeen;
    wr(OFF_ID, RESET_KEY);
    check("defaults pulse", 16'(defaultsSeen - idx), 16'h0001);
    rd(OFF_MASK, 2, q);
    check("mask default", q[31:16], MASK_RESET);
    check("control default", q[15:0], CTRL_RESET);
    check("control port", sysControl, CTRL_RESET);
    rd(CFG_OFF[0], 1, q);
    check("config default", q[15:0], CFG_RESET);
    wrap_up();
  end
endmodule
